// ---- verilog/sgcc_pkg.sv ----
// Purpose: shared constants and types for the sleep and generic clock control block
// Assumes: one system clock; clock sources arrive as sampled levels
// Notes:   mask widths, counts and sleep encodings live here
package sgcc_pkg;
  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int SGCC_MASK_W   = 32;              // bits per mask register
  localparam int SGCC_NUM_GCLK = 6;               // generic clock count
  localparam int SGCC_DIV_W    = 8;               // ratio field width
  localparam int SGCC_PB_DIV_W = 4;               // divided bus clock counter width
  localparam int SGCC_SYNC_LAT = 2;               // mask apply latency in cycles
  // ----------------------------------------------------------------
  // reset values and bit positions
  // ----------------------------------------------------------------
  localparam logic [31:0] SGCC_MASK_RST  = 32'hFFFFFFFF; // all modules clocked
  localparam int          SGCC_PM_BIT    = 0;     // manager clock bit in bus-a mask
  localparam int          SGCC_BRIDGE_BIT = 1;    // bus-a bridge bit in hsb mask
  localparam logic [1:0]  SGCC_CNT_ZERO2 = 2'h0;
  // ----------------------------------------------------------------
  // sleep mode indices
  // ----------------------------------------------------------------
  localparam logic [2:0] SGCC_SLP_IDLE    = 3'h0;
  localparam logic [2:0] SGCC_SLP_FROZEN  = 3'h1;
  localparam logic [2:0] SGCC_SLP_STANDBY = 3'h2;
  localparam logic [2:0] SGCC_SLP_STOP    = 3'h3;
  localparam logic [2:0] SGCC_SLP_DEEP    = 3'h4;
  localparam logic [2:0] SGCC_SLP_STATIC  = 3'h5;
  // sleep sequencer states
  typedef enum logic [1:0] {
    SGCC_RUN   = 2'b00,   // normal operation
    SGCC_DRAIN = 2'b01,   // waiting for cpu bus to go idle
    SGCC_SLEEP = 2'b10    // domains stopped
  } sgcc_state_t;
endpackage

// ---- verilog/sgcc_gclk_if.sv ----
// Purpose: carrier between the top and one generic clock channel
// Assumes: sources are sampled levels in the system clock
// Notes:   one instance per generic clock
`timescale 1ns/1ns
interface sgcc_gclk_if;
  logic                  enable;     // software enable
  logic                  pb_stop;    // sleep stops peripheral clocks
  logic [1:0]            src_sel;    // {pll_source_select, oscillator_source_select}
  logic                  div_en;     // divide_enable
  logic [7:0]            ratio;      // division ratio field
  logic [3:0]            sources;    // {pll1, pll0, osc1, osc0}
  logic                  clk;        // generated clock
  logic                  enable_rb;  // enable as software reads it
  modport ctrl (output enable, pb_stop, src_sel, div_en, ratio, sources, input clk, enable_rb);
  modport gen  (input enable, pb_stop, src_sel, div_en, ratio, sources, output clk, enable_rb);
endinterface

// ---- verilog/sgcc_gclk.sv ----
// Purpose: one glitch-free generic clock with source select and even divide
// Assumes: source levels sampled by clock_in; output toggles only on edges
// Notes:   stop lands on the next falling output edge, or at once if output is already low
`timescale 1ns/1ns
module sgcc_gclk
  import sgcc_pkg::*;
(
  input  wire logic clock_in,   // system clock
  input  wire logic sys_rst_in, // async reset, active high
  sgcc_gclk_if.gen  g           // channel carrier
);
  import sgcc_pkg::*;
  logic [3:0]            src_q;     // previous source samples
  logic [SGCC_DIV_W:0]   cnt;       // prescaler edge counter
  logic                  out_q;     // generated clock level
  logic                  run;       // channel running
  // ----------------------------------------------------------------
  // source selection and edge detect
  // ----------------------------------------------------------------
  // source from select bits
  wire                   src_now  = g.sources[g.src_sel];
  wire                   src_prev = src_q[g.src_sel];
  wire                   src_edge = src_now & ~src_prev;
  wire [SGCC_DIV_W:0]    last     = {1'b0, g.ratio};
  wire                   tick     = g.div_en ? src_edge & (cnt == last) : src_now ^ src_prev;
  wire                   want_off = ~g.enable | g.pb_stop;
  assign g.clk       = out_q;
  assign g.enable_rb = run;
  // ----------------------------------------------------------------
  // prescaler and output
  // ----------------------------------------------------------------
  // sample all sources every cycle
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      src_q <= 4'h0;
    end else begin
      src_q <= g.sources;
    end
  end
  // run state, counter and output level
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      run   <= 1'b0;
      cnt   <= '0;
      out_q <= 1'b0;
    end else if (!run) begin
      cnt   <= '0;
      out_q <= 1'b0;
      run   <= g.enable & ~g.pb_stop;
    end else if (tick) begin
      cnt   <= '0;
      out_q <= ~out_q;
      if (out_q && want_off) begin
        run <= 1'b0;
      end
    end else if (src_edge) begin
      cnt <= cnt + 1'b1;
    end else if (!out_q && want_off) begin
      // already low: stop now
      run <= 1'b0;
    end
  end
endmodule // sgcc_gclk

// ---- verilog/sgcc_top.sv ----
// Purpose: clock mask apply, sleep sequencing and generic clock bank
// Assumes: all control bits are plain ports synchronous to clock_in
// Notes:   clock gates are enables for downstream gating cells
`timescale 1ns/1ns
// How it works
// - mask bit clear stops module clock
// - manager or bridge masked locks mask writes
// - mask write clears ready, sets when applied
// - ready can raise manager interrupt
// - sleep halts cpu and stopped domains
// - qualifying interrupt wakes; unclocked cannot
// - idle stops cpu only, any wake
// - frozen stops cpu and hsb
// - standby stops all synchronous clocks
// - stop also halts oscillators, low regulator
// - deep stop kills bandgap and detectors
// - static stops all oscillators, async wake
// - halt cpu after bus ops complete
// - generic clock source by select bits
// - divide by two times ratio plus one
// - stop on falling edge or at once while low, enable reads one
// - disabling resets prescaler and output
// - clocks four and five feed usb, dac
// - divided bus clocks ignore masks, sleep stops
module sgcc_top
  import sgcc_pkg::*;
#(
  parameter int MASK_W = SGCC_MASK_W,     // bits per mask
  parameter int NGCLK  = SGCC_NUM_GCLK    // generic clock count
) (
  input  wire logic                     clock_in,       // system clock
  input  wire logic                     sys_rst_in,     // async reset, active high
  input  wire logic [1:0]               mask_wr_in,     // mask write strobes: {pb-a, hsb}
  input  wire logic [MASK_W-1:0]        mask_wdata_in,  // mask write data
  input  wire logic                     ready_ie_in,    // mask ready interrupt enable
  input  wire logic                     sleep_in,       // sleep instruction pulse
  input  wire logic [2:0]               sleep_mode_in,  // sleep mode index
  input  wire logic                     cpu_bus_busy_in,// cpu has outstanding bus ops
  input  wire logic                     irq_any_in,     // any interrupt
  input  wire logic                     irq_pb_in,      // peripheral module interrupt
  input  wire logic                     irq_rtc_in,     // real-time counter interrupt
  input  wire logic                     irq_ext_in,     // external interrupt, sync mode
  input  wire logic                     irq_ext_async_in,// external interrupt, async mode
  input  wire logic                     reset_pin_in,   // reset pin wake request
  input  wire logic [NGCLK-1:0]         gclk_en_in,     // generic_clock_enable bits
  input  wire logic [NGCLK-1:0]         gclk_pll_in,    // pll_source_select bits
  input  wire logic [NGCLK-1:0]         gclk_osc_in,    // oscillator_source_select bits
  input  wire logic [NGCLK-1:0]         gclk_div_en_in, // divide_enable bits
  input  wire logic [NGCLK*SGCC_DIV_W-1:0] gclk_ratio_in,// ratio fields
  input  wire logic [3:0]               sources_in,     // {pll1, pll0, osc1, osc0}
  input  wire logic [SGCC_PB_DIV_W-1:0] pb_div_in,      // divided bus clock ratio
  output logic [MASK_W-1:0]             hsb_gate_out,   // hsb module clock enables
  output logic [MASK_W-1:0]             pba_gate_out,   // bus-a module clock enables
  output logic                          cpu_clk_en_out, // cpu clock enable
  output logic                          mask_ready_out, // mask_ready_flag
  output logic                          pm_irq_out,     // power_manager interrupt
  output logic                          osc_run_out,    // main oscillators, plls, system_timer
  output logic                          slow_osc_run_out,// 32 kHz and internal_rc_oscillator
  output logic                          analog_on_out,  // bandgap and both drop detectors
  output logic                          reg_full_out,   // regulator full power
  output logic [3:0]                    gclk_pin_out,   // generic clock pins 0..3
  output logic                          usb_gclk_out,   // usb_generic_clock
  output logic                          dac_gclk_out,   // audio_dac_generic_clock
  output logic [NGCLK-1:0]              gclk_en_rb_out, // enable readback
  output logic                          pb_div_clk_out  // divided bus clock
);
  import sgcc_pkg::*;
  // ----------------------------------------------------------------
  // mask registers
  // ----------------------------------------------------------------
  logic [MASK_W-1:0]  hsb_mask;      // hsb mask register
  logic [MASK_W-1:0]  pba_mask;      // bus-a mask register
  logic [1:0]         apply_cnt;     // cycles until mask is applied
  logic               locked;        // writes refused until reset
  sgcc_state_t        state;         // sleep sequencer state
  sgcc_state_t        next_state;    // next sequencer state
  logic [2:0]         mode;          // latched sleep index
  wire                lock_now = ~pba_mask[SGCC_PM_BIT] | ~hsb_mask[SGCC_BRIDGE_BIT];
  wire                wr_ok    = |mask_wr_in & ~locked;
  // ----------------------------------------------------------------
  // sleep decode
  // ----------------------------------------------------------------
  wire in_sleep   = (state == SGCC_SLEEP);
  wire stop_cpu   = (state != SGCC_RUN) & in_sleep;
  wire stop_hsb   = in_sleep & (mode >= SGCC_SLP_FROZEN);
  wire stop_pb    = in_sleep & (mode >= SGCC_SLP_STANDBY);
  wire stop_osc   = in_sleep & (mode >= SGCC_SLP_STOP);
  wire stop_ana   = in_sleep & (mode >= SGCC_SLP_DEEP);
  wire stop_slow  = in_sleep & (mode == SGCC_SLP_STATIC);
  logic wake;
  always_comb begin
    case (mode)
      SGCC_SLP_IDLE:    wake = irq_any_in;
      SGCC_SLP_FROZEN:  wake = irq_pb_in;
      SGCC_SLP_STANDBY: wake = irq_rtc_in | irq_ext_in;
      SGCC_SLP_STOP,
      SGCC_SLP_DEEP:    wake = irq_rtc_in | irq_ext_in | reset_pin_in;
      SGCC_SLP_STATIC:  wake = irq_ext_async_in | reset_pin_in;
      default:          wake = irq_any_in;
    endcase
  end
  // sequencer next state
  always_comb begin
    next_state = state;
    case (state)
      SGCC_RUN: begin
        if (sleep_in) begin
          next_state = SGCC_DRAIN;
        end
      end
      SGCC_DRAIN: begin
        if (!cpu_bus_busy_in) begin
          next_state = SGCC_SLEEP;
        end
      end
      SGCC_SLEEP: begin
        if (wake) begin
          next_state = SGCC_RUN;
        end
      end
      default: next_state = SGCC_RUN;
    endcase
  end
  // sequencer registers
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state <= SGCC_RUN;
      mode  <= SGCC_SLP_IDLE;
    end else begin
      state <= next_state;
      if (state == SGCC_RUN && sleep_in) begin
        mode <= sleep_mode_in;
      end
    end
  end
  // mask writes; lock cleared only by reset
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      hsb_mask <= SGCC_MASK_RST[MASK_W-1:0];
      pba_mask <= SGCC_MASK_RST[MASK_W-1:0];
      locked   <= 1'b0;
    end else begin
      if (mask_wr_in[0] && !locked) begin
        hsb_mask <= mask_wdata_in;
      end
      if (mask_wr_in[1] && !locked) begin
        pba_mask <= mask_wdata_in;
      end
      if (lock_now) begin
        locked <= 1'b1;
      end
    end
  end
  // ready clears on write, sets when applied
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      apply_cnt      <= SGCC_CNT_ZERO2;
      mask_ready_out <= 1'b1;
    end else if (wr_ok) begin
      apply_cnt      <= 2'(SGCC_SYNC_LAT);
      mask_ready_out <= 1'b0;
    end else if (apply_cnt != SGCC_CNT_ZERO2) begin
      apply_cnt      <= apply_cnt - 2'h1;
      mask_ready_out <= (apply_cnt == 2'h1);
    end
  end
  // ----------------------------------------------------------------
  // gated outputs, registered
  // ----------------------------------------------------------------
  // mask gates; sleep overrides mask
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      hsb_gate_out     <= SGCC_MASK_RST[MASK_W-1:0];
      pba_gate_out     <= SGCC_MASK_RST[MASK_W-1:0];
      cpu_clk_en_out   <= 1'b1;
      osc_run_out      <= 1'b1;
      slow_osc_run_out <= 1'b1;
      analog_on_out    <= 1'b1;
      reg_full_out     <= 1'b1;
      pm_irq_out       <= 1'b0;
    end else begin
      hsb_gate_out     <= stop_hsb ? '0 : hsb_mask;
      pba_gate_out     <= stop_pb  ? '0 : pba_mask;
      cpu_clk_en_out   <= ~stop_cpu;
      osc_run_out      <= ~stop_osc;
      slow_osc_run_out <= ~stop_slow;
      analog_on_out    <= ~stop_ana;
      reg_full_out     <= ~stop_osc;
      pm_irq_out       <= ready_ie_in & mask_ready_out;
    end
  end
  // ----------------------------------------------------------------
  // generic clock bank
  // ----------------------------------------------------------------
  logic [NGCLK-1:0] gclk;   // raw channel clocks
  genvar i;
  generate
    for (i = 0; i < NGCLK; i++) begin : g_gclk
      sgcc_gclk_if ch ();
      assign ch.enable  = gclk_en_in[i];
      assign ch.pb_stop = stop_pb;
      assign ch.src_sel = {gclk_pll_in[i], gclk_osc_in[i]};
      assign ch.div_en  = gclk_div_en_in[i];
      assign ch.ratio   = gclk_ratio_in[i*SGCC_DIV_W +: SGCC_DIV_W];
      assign ch.sources = sources_in;
      assign gclk[i]    = ch.clk;
      sgcc_gclk u_gclk (
        .clock_in   (clock_in),
        .sys_rst_in (sys_rst_in),
        .g          (ch.gen)
      );
      // readback, registered
      always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
          gclk_en_rb_out[i] <= 1'b0;
        end else begin
          gclk_en_rb_out[i] <= ch.enable_rb | ch.enable;
        end
      end
    end
  endgenerate
  // clocks to pins, usb and dac
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      gclk_pin_out <= 4'h0;
      usb_gclk_out <= 1'b0;
      dac_gclk_out <= 1'b0;
    end else begin
      gclk_pin_out <= gclk[3:0];
      usb_gclk_out <= gclk[4];
      dac_gclk_out <= gclk[5];
    end
  end
  // ----------------------------------------------------------------
  // divided peripheral bus clock
  // ----------------------------------------------------------------
  logic [SGCC_PB_DIV_W-1:0] pb_cnt;   // divider counter
  // no mask, only sleep stops it
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pb_cnt         <= '0;
      pb_div_clk_out <= 1'b0;
    end else if (stop_pb) begin
      pb_cnt         <= '0;
      pb_div_clk_out <= 1'b0;
    end else if (pb_cnt == pb_div_in) begin
      pb_cnt         <= '0;
      pb_div_clk_out <= ~pb_div_clk_out;
    end else begin
      pb_cnt <= pb_cnt + 1'b1;
    end
  end
endmodule // sgcc_top

// ---- tb/sgcc_top_props.sv ----
// Purpose: port-level checks of mask ready, sleep levels and generic clocks
// Assumes: one clock domain, async reset active high
// Notes:   lock is judged from the applied gates, so masks are not written in sleep
`timescale 1ns/1ns
module sgcc_top_props
  import sgcc_pkg::*;
#(
  parameter int MASK_W = SGCC_MASK_W,  // bits per mask
  parameter int NGCLK  = SGCC_NUM_GCLK // generic clock count
) (
  input wire logic              clock_in,         // clock
  input wire logic              sys_rst_in,       // reset
  input wire logic [1:0]        mask_wr_in,       // mask strobes
  input wire logic              ready_ie_in,      // ready irq enable
  input wire logic              cpu_bus_busy_in,  // cpu bus busy
  input wire logic [MASK_W-1:0] hsb_gate_out,     // hsb gates
  input wire logic [MASK_W-1:0] pba_gate_out,     // bus-a gates
  input wire logic              cpu_clk_en_out,   // cpu enable
  input wire logic              mask_ready_out,   // ready flag
  input wire logic              pm_irq_out,       // manager irq
  input wire logic              osc_run_out,      // main osc
  input wire logic              slow_osc_run_out, // slow osc
  input wire logic              analog_on_out,    // bandgap, detectors
  input wire logic              reg_full_out,     // regulator
  input wire logic [3:0]        gclk_pin_out,     // clock pins
  input wire logic              usb_gclk_out,     // usb clock
  input wire logic              dac_gclk_out,     // dac clock
  input wire logic [NGCLK-1:0]  gclk_en_rb_out    // readback
);
  // ----------------------------------------------------------------
  // helpers and defaults
  // ----------------------------------------------------------------
  wire [5:0] gpins  = {dac_gclk_out, usb_gclk_out, gclk_pin_out};              // all generic clocks
  wire       locked = !pba_gate_out[SGCC_PM_BIT] || !hsb_gate_out[SGCC_BRIDGE_BIT]; // writes shut out
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  // ----------------------------------------------------------------
  // mask ready and interrupt
  // ----------------------------------------------------------------
  // write clears ready
  AST_WR_CLR: assert property ((|mask_wr_in) && !locked |-> ##[1:2] !mask_ready_out) else $error("ready kept");
  AST_RDY_SET: assert property ($fell(mask_ready_out) |-> ##[1:3] mask_ready_out) else $error("ready stuck");
  AST_LOCK: assert property (mask_ready_out && locked && (|mask_wr_in) |=> mask_ready_out [*2])
    else $error("locked write taken");
  AST_IRQ_ON: assert property ($rose(pm_irq_out) |-> $past(ready_ie_in && mask_ready_out))
    else $error("irq without cause");
  AST_IRQ_OFF: assert property (!ready_ie_in || !mask_ready_out |=> !pm_irq_out) else $error("irq stays");
  // ----------------------------------------------------------------
  // sleep levels, ordered by depth
  // ----------------------------------------------------------------
  // busy keeps cpu
  AST_BUSY: assert property ((cpu_clk_en_out && cpu_bus_busy_in) [*2] |=> cpu_clk_en_out)
    else $error("cpu stopped while busy");
  AST_AWAKE: assert property (cpu_clk_en_out |-> osc_run_out && slow_osc_run_out && analog_on_out && reg_full_out)
    else $error("domain off while awake");
  AST_REG_OSC: assert property (reg_full_out == osc_run_out) else $error("regulator mismatch");
  AST_OSC_PB: assert property (!osc_run_out |-> pba_gate_out == '0 && hsb_gate_out == '0)
    else $error("gates on in stop");
  AST_ANA: assert property (!analog_on_out |-> !osc_run_out) else $error("analog off too early");
  AST_SLOW: assert property (!slow_osc_run_out |-> !analog_on_out) else $error("slow osc off too early");
  // ----------------------------------------------------------------
  // generic clocks
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 6; i++) begin : g_gc
    AST_GC_OFF: assert property ((!gclk_en_rb_out[i]) [*3] |-> !gpins[i]) else $error("gclk while off");
    AST_GC_RB: assert property (gpins[i] |-> gclk_en_rb_out[i] || $past(gclk_en_rb_out[i]))
      else $error("readback dropped early");
  end
  cover property ($rose(mask_ready_out));
  cover property ($rose(pm_irq_out));
  cover property ($fell(osc_run_out));
  cover property ($fell(slow_osc_run_out));
endmodule // sgcc_top_props

bind sgcc_top sgcc_top_props #(.MASK_W(MASK_W), .NGCLK(NGCLK)) u_props (
  .clock_in(clock_in), .sys_rst_in(sys_rst_in), .mask_wr_in(mask_wr_in), .ready_ie_in(ready_ie_in),
  .cpu_bus_busy_in(cpu_bus_busy_in), .hsb_gate_out(hsb_gate_out), .pba_gate_out(pba_gate_out),
  .cpu_clk_en_out(cpu_clk_en_out), .mask_ready_out(mask_ready_out), .pm_irq_out(pm_irq_out),
  .osc_run_out(osc_run_out), .slow_osc_run_out(slow_osc_run_out), .analog_on_out(analog_on_out),
  .reg_full_out(reg_full_out), .gclk_pin_out(gclk_pin_out), .usb_gclk_out(usb_gclk_out),
  .dac_gclk_out(dac_gclk_out), .gclk_en_rb_out(gclk_en_rb_out));

// ---- tb/tb_top.sv ----
// Purpose: self-checking bench for sgcc_top
// Assumes: inputs move on the falling edge
// Notes:   source bit k toggles with period 2^(k+1) cycles
`timescale 1ns/1ns
module tb_top;
  import sgcc_pkg::*;
  // ----------------------------------------------------------------
  // stimulus, observation, model
  // ----------------------------------------------------------------
  logic        clock_in = 1'b0, sys_rst_in = 1'b1;      // clock, reset
  logic [1:0]  mask_wr_in = 2'h0;                       // mask strobes
  logic [31:0] mask_wdata_in = 32'h0;                   // mask data
  logic        ready_ie_in = 1'b0, sleep_in = 1'b0;     // irq enable, sleep pulse
  logic [2:0]  sleep_mode_in = 3'h0;                    // sleep index
  logic        cpu_bus_busy_in = 1'b0;                  // cpu bus busy
  logic [5:0]  wk = 6'h0;                               // {any, pb, rtc, ext, async, pin}
  logic [5:0]  g_en = 6'h0, g_pll = 6'h0, g_osc = 6'h0, g_div = 6'h0; // generic clock controls
  logic [47:0] g_ratio = 48'h0;                         // ratio fields
  logic [3:0]  cyc = 4'h0, pb_div_in = 4'h0;            // source pattern, bus divider
  logic [31:0] hsb_gate_out, pba_gate_out;              // gates
  logic        cpu_clk_en_out, mask_ready_out, pm_irq_out, osc_run_out; // status
  logic        slow_osc_run_out, analog_on_out, reg_full_out, usb_gclk_out, dac_gclk_out, pb_div_clk_out;
  logic [3:0]  gclk_pin_out;                            // clock pins
  logic [5:0]  gclk_en_rb_out;                          // readback
  logic [31:0] m_hsb = 32'hFFFFFFFF, m_pba = 32'hFFFFFFFF; // model masks
  int          n_mismatch = 0, n_checks = 0;            // counters
  // wake and decoy sources per sleep index
  logic [5:0]  wake [6] = '{6'h20, 6'h30, 6'h28, 6'h01, 6'h24, 6'h22};
  logic [5:0]  decoy [6] = '{6'h00, 6'h20, 6'h30, 6'h30, 6'h30, 6'h2C};
  wire  [6:0]  obs = {pb_div_clk_out, dac_gclk_out, usb_gclk_out, gclk_pin_out}; // clocks seen
  wire  [5:0]  slp = {|hsb_gate_out, |pba_gate_out, osc_run_out, slow_osc_run_out, analog_on_out, reg_full_out};
  wire  [3:0]  st = {!gclk_en_rb_out[0], cpu_clk_en_out, !cpu_clk_en_out, mask_ready_out}; // wait targets
  always #4 clock_in = ~clock_in;
  always @(negedge clock_in) cyc <= cyc + 4'h1;
  sgcc_top uut (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in), .mask_wr_in(mask_wr_in), .mask_wdata_in(mask_wdata_in),
    .ready_ie_in(ready_ie_in), .sleep_in(sleep_in), .sleep_mode_in(sleep_mode_in),
    .cpu_bus_busy_in(cpu_bus_busy_in), .irq_any_in(wk[5]), .irq_pb_in(wk[4]), .irq_rtc_in(wk[3]),
    .irq_ext_in(wk[2]), .irq_ext_async_in(wk[1]), .reset_pin_in(wk[0]), .gclk_en_in(g_en),
    .gclk_pll_in(g_pll), .gclk_osc_in(g_osc), .gclk_div_en_in(g_div), .gclk_ratio_in(g_ratio),
    .sources_in(cyc), .pb_div_in(pb_div_in), .hsb_gate_out(hsb_gate_out), .pba_gate_out(pba_gate_out),
    .cpu_clk_en_out(cpu_clk_en_out), .mask_ready_out(mask_ready_out), .pm_irq_out(pm_irq_out),
    .osc_run_out(osc_run_out), .slow_osc_run_out(slow_osc_run_out), .analog_on_out(analog_on_out),
    .reg_full_out(reg_full_out), .gclk_pin_out(gclk_pin_out), .usb_gclk_out(usb_gclk_out),
    .dac_gclk_out(dac_gclk_out), .gclk_en_rb_out(gclk_en_rb_out), .pb_div_clk_out(pb_div_clk_out));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk_v(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_p(input int got, input int exp);
    chk_v(got, exp);
  endtask
  // a spent bound fails the run
  task automatic hang;
    n_mismatch++;
    $display("BAD t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    end_of_test;
  endtask
  task automatic wait_st(input int b);
    for (int n = 0; n < 64 && st[b] !== 1'b1; n++) @(negedge clock_in);
    if (st[b] !== 1'b1) hang;
  endtask
  // spacing of last two rising edges
  task automatic period(input int b, output int p);
    int e, t0;
    logic o;
    e = 0; t0 = 0; p = 0; o = obs[b];
    for (int n = 0; n < 600 && e < 3; n++) begin
      @(negedge clock_in);
      if (obs[b] === 1'b1 && o === 1'b0) begin
        e++;
        p = n - t0;
        t0 = n;
      end
      o = obs[b];
    end
    if (e < 3) hang;
  endtask
  task automatic watch(output logic [6:0] c);
    logic [6:0] o;
    c = 7'h0; o = obs;
    repeat (40) begin
      @(negedge clock_in);
      c = c | (o ^ obs);
      o = obs;
    end
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    int p;
    logic [31:0] d;
    logic [6:0] c;
    void'($urandom(32'h75cb));
    repeat (20) @(negedge clock_in);
    sys_rst_in = 1'b0;
    chk_v({slp, mask_ready_out, cpu_clk_en_out}, 8'hFF);
    for (int i = 0; i < 4; i++) begin
      d = $urandom | 32'h3;
      ready_ie_in = i > 1;
      mask_wr_in = i[0] ? 2'h2 : 2'h1;
      mask_wdata_in = (i == 3) ? ~d | 32'h3 : d;
      if (i == 3) @(negedge clock_in);
      if (i == 3) mask_wdata_in = d;
      @(negedge clock_in);
      mask_wr_in = 2'h0;
      if (i[0]) m_pba = d;
      else m_hsb = d;
      @(negedge clock_in);
      chk_v(mask_ready_out, 1'b0);
      wait_st(0);
      chk_v(hsb_gate_out, m_hsb);
      chk_v(pba_gate_out, m_pba);
      @(negedge clock_in);
      chk_v(pm_irq_out, ready_ie_in);
    end
    $display("mask test done");
    pb_div_in = $urandom % 16;
    g_pll = 6'b001100; g_osc = 6'b101010; g_div = 6'h3F;
    g_ratio = {$urandom, $urandom} & 48'h010101010101;
    g_en = 6'h3F;
    for (int i = 0; i < 6; i++) begin
      period(i, p);
      chk_p(p, 2 * (g_ratio[i*8 +: 8] + 1) * (2 << (i % 4)));
    end
    period(6, p);
    chk_p(p, 2 * (pb_div_in + 1));
    g_en = 6'h3E;
    wait_st(3);
    watch(c);
    chk_v({c[0], obs[0]}, 2'h0);
    g_en = 6'h3F;
    $display("generic clock test done");
    for (int i = 0; i < 6; i++) begin
      sleep_in = 1'b1; sleep_mode_in = i[2:0]; cpu_bus_busy_in = 1'b1;
      @(negedge clock_in);
      sleep_in = 1'b0;
      repeat (4) @(negedge clock_in);
      chk_v(cpu_clk_en_out, 1'b1);
      cpu_bus_busy_in = 1'b0;
      wait_st(1);
      @(negedge clock_in);
      chk_v(slp, {i < 1, i < 2, i < 3, i < 5, i < 4, i < 3});
      if (i > 1) watch(c);
      watch(c);
      chk_v(c, i < 2 ? 7'h7F : 7'h00);
      wk = decoy[i];
      repeat (6) @(negedge clock_in);
      chk_v(cpu_clk_en_out, 1'b0);
      wk = wake[i];
      wait_st(2);
      wk = 6'h0;
      @(negedge clock_in);
      chk_v(slp, 6'h3F);
      chk_v(hsb_gate_out ^ pba_gate_out, m_hsb ^ m_pba);
    end
    $display("sleep test done");
    d = $urandom & 32'hFFFFFFFE;
    mask_wr_in = 2'h2; mask_wdata_in = d;
    @(negedge clock_in);
    mask_wr_in = 2'h0; m_pba = d;
    @(negedge clock_in);
    wait_st(0);
    chk_v(pba_gate_out, m_pba);
    mask_wr_in = 2'h1; mask_wdata_in = 32'h0000FFFF;
    @(negedge clock_in);
    mask_wr_in = 2'h0;
    repeat (3) @(negedge clock_in);
    chk_v(mask_ready_out, 1'b1);
    chk_v(hsb_gate_out, m_hsb);
    sys_rst_in = 1'b1;
    repeat (3) @(negedge clock_in);
    sys_rst_in = 1'b0;
    chk_v(hsb_gate_out & pba_gate_out, SGCC_MASK_RST);
    $display("lock test done");
    end_of_test;
  end
endmodule // tb_top
